// *** rtl/cfec_pkg.sv ***
/*
 * cfec_pkg: shared constants and types of the coupled machine environment
 * configuration bank: register offsets, field layouts, reset values.
 * Assumes a byte-wide register port with 8-bit offsets.
 */
package cfec_pkg;

	localparam int unsigned MACHINES = 6;
	localparam int unsigned PAIRS    = 3;

	// register offsets
	localparam logic [7:0] OFF_PAIR01 = 8'h15;
	localparam logic [7:0] OFF_PAIR23 = 8'h16;
	localparam logic [7:0] OFF_PAIR45 = 8'h17;
	localparam logic [7:0] OFF_SWEV   = 8'h18;
	localparam logic [7:0] OFF_UNLOCK = 8'h19;

	// reset values
	localparam logic [7:0] RST_PAIR   = 8'h00;
	localparam logic [5:0] RST_SWEV   = 6'h00;
	localparam logic [2:0] RST_UNLOCK = 3'h0;
	localparam logic [7:0] RD_IDLE    = 8'h00;

	// field positions
	localparam int unsigned POS_EVEN_NIB   = 0;
	localparam int unsigned POS_ODD_NIB    = 4;
	localparam int unsigned POS_DRIVE      = 0;
	localparam int unsigned POS_CFG_LO     = 1;
	localparam int unsigned POS_SWEV_LO    = 0;
	localparam int unsigned POS_UL_EN_LO   = 0;
	localparam int unsigned POS_UL_CMD_LO  = 3;
	localparam int unsigned POS_RESVD_LO   = 6;
	localparam logic [1:0]  RESVD_VALUE    = 2'h0;

	// one machine's nibble: legacy four-bit global setting, split in two
	typedef struct packed {
		logic [2:0] couplingCfg;
		logic       mergedDrive;
	} cfec_machine_cfg_t;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cfec_bus_req_t;

endpackage

// *** rtl/cfec_pair_reg.sv ***
/*
 * cfec_pair_reg: one pair configuration register, even machine in the low
 * nibble, odd machine in the high nibble.
 * Assumes the parent decodes the offset and drives a one-cycle write enable.
 */
`timescale 1ns/1ps

module cfec_pair_reg
	import cfec_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// write side
	input  wire logic              wrEn,
	input  wire logic [7:0]        wdata,
	// configuration out
	output cfec_machine_cfg_t      evenCfg,
	output cfec_machine_cfg_t      oddCfg,
	output logic [7:0]             value
);

	logic [7:0] pair_q;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			pair_q <= RST_PAIR;
		else if (wrEn)
			pair_q <= wdata;
	end

	// the struct layout puts the drive bit at bit 0 of each nibble
	assign evenCfg = cfec_machine_cfg_t'(pair_q[POS_EVEN_NIB +: 4]);
	assign oddCfg  = cfec_machine_cfg_t'(pair_q[POS_ODD_NIB +: 4]);
	assign value   = pair_q;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	even_fields_a: assert property (wrEn |=> evenCfg.mergedDrive == $past(wdata[0])
		&& evenCfg.couplingCfg == $past(wdata[3:1]))
		else $error("even machine fields wrong after write");

	odd_fields_a: assert property (wrEn |=> oddCfg.mergedDrive == $past(wdata[4])
		&& oddCfg.couplingCfg == $past(wdata[7:5]))
		else $error("odd machine fields wrong after write");

	pair_hold_a: assert property (!wrEn |=> $stable(value))
		else $error("pair register changed without a write");

endmodule // cfec_pair_reg

// *** rtl/cfec_env_config.sv ***
/*
 * cfec_env_config: environment configuration bank for six event-driven
 * machines in three pairs: coupling config and merged drive per machine,
 * software events, per-pair unlock enable and command.
 * Assumes a register port with one-cycle strobes, never both at once, and
 * read data expected exactly one cycle after the read strobe.
 */
// Added by the designer: strobed register access.
// Behaviour
// - Pair 0/1 register: bit 0 machine 0 drive, bits 3:1 machine 0 config.
// - Pair 0/1 register: bit 4 machine 1 drive, bits 7:5 machine 1 config.
// - Pairs 2/3 and 4/5 same layout; low nibble even, high odd.
// - Old four-bit setting kept as three-bit config plus drive bit.
// - Event register bit n written 1 asserts event n, written 0 clears.
// - Unlock bits 0..2 enable unlock for pairs 0/1, 2/3, 4/5.
// - Unlock bits 3..5 assert unlock command for pairs 0/1, 2/3, 4/5.
`timescale 1ns/1ps

module cfec_env_config
	import cfec_pkg::*;
(
	// clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    rst,
	// register port
	input  wire cfec_bus_req_t           busReq,
	output logic [7:0]                   busRdata,
	// per-machine configuration
	output cfec_machine_cfg_t [5:0]      machineCfg,
	output logic [5:0]                   softEvent,
	// per-pair unlock
	output logic [2:0]                   unlockEnable,
	output logic [2:0]                   unlockCommand
);

	////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic writeHit(input cfec_bus_req_t req, input logic [7:0] off);
		writeHit = req.wr && (req.addr == off);
	endfunction

	function automatic logic readHit(input cfec_bus_req_t req, input logic [7:0] off);
		readHit = req.rd && (req.addr == off);
	endfunction

	// offsets outside the bank read as zero and ignore writes
	function automatic logic inBank(input logic [7:0] off);
		inBank = (off >= OFF_PAIR01) && (off <= OFF_UNLOCK);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pair configuration registers

	logic [7:0] pair01Value;
	logic [7:0] pair23Value;
	logic [7:0] pair45Value;

	cfec_pair_reg u_pair01
	(
		.core_clk (core_clk),
		.rst      (rst),
		.wrEn     (writeHit(busReq, OFF_PAIR01)),
		.wdata    (busReq.wdata),
		.evenCfg  (machineCfg[0]),
		.oddCfg   (machineCfg[1]),
		.value    (pair01Value)
	);

	cfec_pair_reg u_pair23
	(
		.core_clk (core_clk),
		.rst      (rst),
		.wrEn     (writeHit(busReq, OFF_PAIR23)),
		.wdata    (busReq.wdata),
		.evenCfg  (machineCfg[2]),
		.oddCfg   (machineCfg[3]),
		.value    (pair23Value)
	);

	cfec_pair_reg u_pair45
	(
		.core_clk (core_clk),
		.rst      (rst),
		.wrEn     (writeHit(busReq, OFF_PAIR45)),
		.wdata    (busReq.wdata),
		.evenCfg  (machineCfg[4]),
		.oddCfg   (machineCfg[5]),
		.value    (pair45Value)
	);

	////////////////////////////////////////////////////////////////////////
	// software events

	logic [5:0] softEvent_q;

	// level, not pulse: the machine sees the event until software drops it
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			softEvent_q <= RST_SWEV;
		else if (writeHit(busReq, OFF_SWEV))
			softEvent_q <= busReq.wdata[POS_SWEV_LO +: MACHINES];
	end

	assign softEvent = softEvent_q;

	////////////////////////////////////////////////////////////////////////
	// unlock enable and command

	logic [2:0] unlockEnable_q;
	logic [2:0] unlockCommand_q;

	// passed through unfiltered; coupling mode gating is software's job
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			unlockEnable_q <= RST_UNLOCK;
		else if (writeHit(busReq, OFF_UNLOCK))
			unlockEnable_q <= busReq.wdata[POS_UL_EN_LO +: PAIRS];
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			unlockCommand_q <= RST_UNLOCK;
		else if (writeHit(busReq, OFF_UNLOCK))
			unlockCommand_q <= busReq.wdata[POS_UL_CMD_LO +: PAIRS];
	end

	// commands stay asserted until software writes them low; no self-clear
	assign unlockEnable  = unlockEnable_q;
	assign unlockCommand = unlockCommand_q;

	////////////////////////////////////////////////////////////////////////
	// read path

	logic [7:0] busRdata_q;
	logic [7:0] busRdata_d;

	// absent machines need no masking: software keeps their fields zero
	always_comb
	begin
		busRdata_d = RD_IDLE;
		if (readHit(busReq, OFF_PAIR01))
			busRdata_d = pair01Value;
		else if (readHit(busReq, OFF_PAIR23))
			busRdata_d = pair23Value;
		else if (readHit(busReq, OFF_PAIR45))
			busRdata_d = pair45Value;
		else if (readHit(busReq, OFF_SWEV))
			busRdata_d = {RESVD_VALUE, softEvent_q};
		else if (readHit(busReq, OFF_UNLOCK))
			busRdata_d = {RESVD_VALUE, unlockCommand_q, unlockEnable_q};
	end

	// zero outside the answer cycle, so a stale value is never mistaken
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			busRdata_q <= RD_IDLE;
		else
			busRdata_q <= busRdata_d;
	end

	assign busRdata = busRdata_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence wrAt(logic [7:0] off);
		busReq.wr && busReq.addr == off;
	endsequence

	sequence rdAt(logic [7:0] off);
		busReq.rd && busReq.addr == off;
	endsequence

	sequence noWrAt(logic [7:0] off);
		!(busReq.wr && busReq.addr == off);
	endsequence

	pair23_layout_a: assert property (wrAt(OFF_PAIR23) |=>
		machineCfg[2] == $past(busReq.wdata[3:0])
		&& machineCfg[3] == $past(busReq.wdata[7:4]))
		else $error("pair 2/3 layout wrong");

	pair45_layout_a: assert property (wrAt(OFF_PAIR45) |=>
		machineCfg[4] == $past(busReq.wdata[3:0])
		&& machineCfg[5] == $past(busReq.wdata[7:4]))
		else $error("pair 4/5 layout wrong");

	pair_isolation_a: assert property (wrAt(OFF_PAIR01) |=>
		$stable(machineCfg[5:2]))
		else $error("pair 0/1 write disturbed other pairs");

	legacy_readback_a: assert property (wrAt(OFF_PAIR01) ##1 rdAt(OFF_PAIR01) |=>
		busRdata == $past(busReq.wdata, 2))
		else $error("legacy nibble not read back intact");

	event_write_a: assert property (wrAt(OFF_SWEV) |=>
		softEvent == $past(busReq.wdata[5:0]))
		else $error("software event not taken from write");

	event_hold_a: assert property (noWrAt(OFF_SWEV) [*4] |=>
		softEvent == $past(softEvent, 4))
		else $error("software event changed without a write");

	unlock_enable_a: assert property (wrAt(OFF_UNLOCK) |=>
		unlockEnable == $past(busReq.wdata[2:0]))
		else $error("unlock enable not taken from write");

	unlock_command_a: assert property (wrAt(OFF_UNLOCK) |=>
		unlockCommand == $past(busReq.wdata[5:3]))
		else $error("unlock command not taken from write");

	unlock_hold_a: assert property (noWrAt(OFF_UNLOCK) |=>
		$stable(unlockEnable) && $stable(unlockCommand))
		else $error("unlock bits changed without a write");

	reserved_zero_a: assert property ((rdAt(OFF_SWEV) or rdAt(OFF_UNLOCK)) |=>
		busRdata[7:6] == 2'h0)
		else $error("reserved bits did not read zero");

	unlock_readback_a: assert property (rdAt(OFF_UNLOCK) |=>
		busRdata[5:0] == $past({unlockCommand, unlockEnable}))
		else $error("unlock register read back wrong");

	idle_read_a: assert property (!busReq.rd |=> busRdata == 8'h00)
		else $error("read data outside the answer cycle");

	// field order inside each nibble matters to the machines, not only the nibble
	pair23_fields_a: assert property (wrAt(OFF_PAIR23) |=>
		machineCfg[2].mergedDrive == $past(busReq.wdata[0])
		&& machineCfg[2].couplingCfg == $past(busReq.wdata[3:1])
		&& machineCfg[3].mergedDrive == $past(busReq.wdata[4])
		&& machineCfg[3].couplingCfg == $past(busReq.wdata[7:5]))
		else $error("pair 2/3 field positions wrong");

	pair45_fields_a: assert property (wrAt(OFF_PAIR45) |=>
		machineCfg[4].mergedDrive == $past(busReq.wdata[0])
		&& machineCfg[4].couplingCfg == $past(busReq.wdata[3:1])
		&& machineCfg[5].mergedDrive == $past(busReq.wdata[4])
		&& machineCfg[5].couplingCfg == $past(busReq.wdata[7:5]))
		else $error("pair 4/5 field positions wrong");

	// every write touches its own register only
	pair23_isolation_a: assert property (wrAt(OFF_PAIR23) |=>
		$stable(machineCfg[1:0]) && $stable(machineCfg[5:4]))
		else $error("pair 2/3 write disturbed other pairs");

	pair45_isolation_a: assert property (wrAt(OFF_PAIR45) |=>
		$stable(machineCfg[3:0]))
		else $error("pair 4/5 write disturbed other pairs");

	event_isolation_a: assert property (wrAt(OFF_SWEV) |=>
		$stable(machineCfg) && $stable(unlockEnable) && $stable(unlockCommand))
		else $error("event write disturbed other registers");

	unlock_isolation_a: assert property (wrAt(OFF_UNLOCK) |=>
		$stable(machineCfg) && $stable(softEvent))
		else $error("unlock write disturbed other registers");

	pair23_readback_a: assert property (rdAt(OFF_PAIR23) |=>
		busRdata == $past({machineCfg[3], machineCfg[2]}))
		else $error("pair 2/3 register read back wrong");

	pair45_readback_a: assert property (rdAt(OFF_PAIR45) |=>
		busRdata == $past({machineCfg[5], machineCfg[4]}))
		else $error("pair 4/5 register read back wrong");

	event_readback_a: assert property (rdAt(OFF_SWEV) |=>
		busRdata[5:0] == $past(softEvent))
		else $error("event register read back wrong");

	// write then read at once must return the new value, not the old
	event_turnaround_a: assert property (wrAt(OFF_SWEV) ##1 rdAt(OFF_SWEV) |=>
		busRdata[5:0] == $past(busReq.wdata[5:0], 2))
		else $error("event read after write returned old value");

	// a read never clears an event or any other setting
	read_no_effect_a: assert property (busReq.rd |=>
		$stable(machineCfg) && $stable(softEvent)
		&& $stable(unlockEnable) && $stable(unlockCommand))
		else $error("a read changed a register");

	// gaps around the bank must stay silent
	unmapped_read_a: assert property (busReq.rd && !inBank(busReq.addr) |=>
		busRdata == 8'h00)
		else $error("unmapped offset read nonzero");

	unmapped_write_a: assert property (busReq.wr && !inBank(busReq.addr) |=>
		$stable(machineCfg) && $stable(softEvent)
		&& $stable(unlockEnable) && $stable(unlockCommand))
		else $error("unmapped write changed a register");

	// reset is masked above, so the release edge is where its values show
	reset_clear_a: assert property ($fell(rst) |->
		machineCfg == 24'h000000 && softEvent == 6'h00 && unlockEnable == 3'h0
		&& unlockCommand == 3'h0 && busRdata == 8'h00)
		else $error("outputs not clear after reset");

endmodule // cfec_env_config

// *** testbench/cfec_testbench.sv ***
/*
 * testbench: self-checking bench for the environment configuration bank.
 * Assumes the register port contract of the bank: one-cycle strobes, read
 * data in the cycle after the read strobe only, writes visible one cycle on.
 */
`timescale 1ns/1ps

module testbench
	import cfec_pkg::*;
;
	logic                    core_clk;
	logic                    rst;
	cfec_bus_req_t           busReq;
	logic [7:0]              busRdata;
	cfec_machine_cfg_t [5:0] machineCfg;
	logic [5:0]              softEvent;
	logic [2:0]              unlockEnable;
	logic [2:0]              unlockCommand;
	int                      numErrors;
	int                      cmpCount;
	logic [7:0]              shadow [5];
	logic [7:0]              rows [10][3];

	cfec_env_config dut
	(
		.core_clk      (core_clk),
		.rst           (rst),
		.busReq        (busReq),
		.busRdata      (busRdata),
		.machineCfg    (machineCfg),
		.softEvent     (softEvent),
		.unlockEnable  (unlockEnable),
		.unlockCommand (unlockCommand)
	);

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic endSim();
		if (numErrors == 0 && cmpCount > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		busReq <= '0;
		#1;
	endtask

	// read data must stand one cycle only, then return to zero
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		busReq <= '0;
		#1;
		chk(busRdata, exp);
		@(posedge core_clk);
		#1;
		chk(busRdata, 8'h00);
	endtask

	// outputs against the shadow copy of the five registers
	task automatic chkOuts();
		chk(machineCfg, {shadow[2], shadow[1], shadow[0]});
		for (int m = 0; m < 6; m++)
		begin
			chk(machineCfg[m].mergedDrive, shadow[m / 2][4 * (m % 2)]);
			chk(machineCfg[m].couplingCfg, shadow[m / 2][4 * (m % 2) + 1 +: 3]);
		end
		chk(softEvent, shadow[3][5:0]);
		chk(unlockEnable, shadow[4][2:0]);
		chk(unlockCommand, shadow[4][5:3]);
	endtask

	initial
	begin
		#(10000 * 25);
		numErrors++;
		endSim();
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		// address, write data, read back
		// pairs are set up before any unlock row reserved bits written zero
		// all six machines exist here, so no field is reserved
		rows = '{'{8'h15, 8'hA5, 8'hA5}, '{8'h16, 8'h3C, 8'h3C}, '{8'h17, 8'hF0, 8'hF0},
			'{8'h18, 8'h3F, 8'h3F}, '{8'h19, 8'h3F, 8'h3F}, '{8'h18, 8'h15, 8'h15},
			'{8'h19, 8'h2A, 8'h2A}, '{8'h19, 8'h15, 8'h15}, '{8'h20, 8'hFF, 8'h00},
			'{8'h14, 8'hFF, 8'h00}};
		numErrors = 0;
		cmpCount = 0;
		shadow = '{default: 8'h00};
		busReq = '0;
		rst = 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		chkOuts();
		for (int i = 0; i < 5; i++)
			rd(8'h15 + 8'(i), 8'h00);
		for (int i = 0; i < 10; i++)
		begin
			wr(rows[i][0], rows[i][1]);
			if (rows[i][0] >= 8'h15 && rows[i][0] <= 8'h19)
				shadow[rows[i][0] - 8'h15] = rows[i][2];
			chkOuts();
			rd(rows[i][0], rows[i][2]);
		end
		// reserved bits written as ones on purpose: they must stay zero
		wr(8'h18, 8'hFF);
		rd(8'h18, 8'h3F);
		wr(8'h19, 8'hFF);
		rd(8'h19, 8'h3F);
		shadow[3] = 8'h3F;
		shadow[4] = 8'h3F;
		chkOuts();
		// back to back: write then read of the same register at once
		@(posedge core_clk);
		busReq <= '{addr: 8'h18, wdata: 8'h21, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		busReq <= '{addr: 8'h18, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		busReq <= '0;
		#1;
		chk(busRdata, 8'h21);
		shadow[3] = 8'h21;
		// events must not decay while other registers change
		for (int i = 0; i < 20; i++)
			wr(8'h15, 8'(i));
		shadow[0] = 8'h13;
		chkOuts();
		wr(8'h18, 8'h01);
		shadow[3] = 8'h01;
		chkOuts();
		// asynchronous reset in mid-run clears everything at once
		@(posedge core_clk);
		rst <= 1'b1;
		#1;
		shadow = '{default: 8'h00};
		chkOuts();
		@(posedge core_clk);
		rst <= 1'b0;
		rd(8'h18, 8'h00);
		rd(8'h15, 8'h00);
		endSim();
	end

endmodule // testbench
